// [btd_pkg.sv]
package btd_pkg;
   // ------------------------------------------------------------
   // widths and opcodes
   // ------------------------------------------------------------
   localparam int unsigned OFS_W = 32; // code-segment offset width
   localparam logic [7:0] OP_ONE_BYTE_BREAK = 8'hCC;
   localparam logic [7:0] OP_SOFT_INT = 8'hCD;
   localparam logic [7:0] OP_EMU_BREAK = 8'hF1;
   localparam logic [7:0] BREAK_VECTOR = 8'h03;
   localparam logic [7:0] DEBUG_VECTOR = 8'h01;
   localparam logic [7:0] MCHECK_VECTOR = 8'h12;
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;

   // ------------------------------------------------------------
   // register map (word addresses on the plain port)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_DEBUG_CTL = 4'h0;
   localparam logic [3:0] ADDR_BR_SRC = 4'h1;
   localparam logic [3:0] ADDR_BR_TGT = 4'h2;
   localparam logic [3:0] ADDR_EX_SRC = 4'h3;
   localparam logic [3:0] ADDR_EX_TGT = 4'h4;
   localparam logic [3:0] ADDR_DBG_STAT = 4'h5;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned CTL_RECORD_BIT = 0;
   localparam int unsigned CTL_STEP_BIT = 1;
   localparam int unsigned STAT_SINGLE_STEP_BIT = 14;
   localparam logic [31:0] OFS_RESET = 32'h0000_0000;

   // kind of retired event
   typedef enum logic [1:0] {
      BTD_EV_NONE = 2'b00,
      BTD_EV_BRANCH = 2'b01,
      BTD_EV_EXCEPT = 2'b10
   } btd_ev_t;
endpackage

// [btd_break_decode.sv]
`timescale 1ns/100ps
// ------------------------------------------------------------
// breakpoint opcode decoder
// ------------------------------------------------------------
module btd_break_decode (
   input wire logic [7:0] i_op0,
   input wire logic [7:0] i_op1,
   output logic o_is_break,
   output logic o_is_emu_break,
   output logic [1:0] o_len
);
   // classify the leading bytes
   always_comb begin
      o_is_break = 1'b0;
      o_is_emu_break = 1'b0;
      o_len = btd_pkg::LEN_ONE;
      if (i_op0 == btd_pkg::OP_ONE_BYTE_BREAK) begin
         o_is_break = 1'b1;
         o_len = btd_pkg::LEN_ONE;
      end else if (i_op0 == btd_pkg::OP_SOFT_INT && i_op1 == btd_pkg::BREAK_VECTOR) begin
         o_is_break = 1'b1;
         o_len = btd_pkg::LEN_TWO;
      end else if (i_op0 == btd_pkg::OP_EMU_BREAK) begin
         o_is_emu_break = 1'b1;
      end
   end
endmodule // btd_break_decode

// [btd_branch_trace.sv]
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/100ps
// Function
// - breakpoint opcodes vector to breakpoint handler
// - one-byte break is one byte long
// - record transfers only while record enable set
// - branch: source offset and target offset
// - exception: interrupted offset and handler entry
// - exceptions copy branch pair into exception pair
// - debug, machine check, emulator break skip copy
// - debug exception clears record enable
// - debug exception keeps recorded contents
// - records hold code-segment offsets
// - branch stepping needs step bit and trap
// - branch stepping traps on every transfer
// - debug exception clears step bit, trap
// - step bit clear, trap set: every instruction
// - stepping trap sets single-step status bit
module btd_branch_trace #(
   parameter int unsigned OFS_W = btd_pkg::OFS_W
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   // retirement stream
   input wire logic i_retire,
   input wire logic [7:0] i_op0,
   input wire logic [7:0] i_op1,
   input wire logic i_is_branch,
   input wire logic [OFS_W-1:0] i_src_ofs,
   input wire logic [OFS_W-1:0] i_tgt_ofs,
   input wire logic i_except,
   input wire logic [7:0] i_except_vec,
   input wire logic [OFS_W-1:0] i_handler_ofs,
   input wire logic i_trap_flag,
   input wire logic i_flag_write,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [OFS_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [OFS_W-1:0] o_rdata,
   // exception requests to the core
   output logic o_break_req,
   output logic [1:0] o_break_len,
   output logic o_debug_req,
   output logic o_trap_flag
);
   logic dec_break;
   logic dec_emu;
   logic [1:0] dec_len;

   // ------------------------------------------------------------
   // opcode decode
   // ------------------------------------------------------------
   btd_break_decode u_dec (
      .i_op0(i_op0),
      .i_op1(i_op1),
      .o_is_break(dec_break),
      .o_is_emu_break(dec_emu),
      .o_len(dec_len)
   );

   logic rec_en_reg, rec_en_next;
   logic step_en_reg, step_en_next;
   logic trap_reg, trap_next;
   logic ss_stat_reg, ss_stat_next;
   logic [OFS_W-1:0] br_src_reg, br_src_next;
   logic [OFS_W-1:0] br_tgt_reg, br_tgt_next;
   logic [OFS_W-1:0] ex_src_reg, ex_src_next;
   logic [OFS_W-1:0] ex_tgt_reg, ex_tgt_next;
   logic break_req_reg, break_req_next;
   logic [1:0] break_len_reg, break_len_next;
   logic dbg_req_reg, dbg_req_next;
   logic [OFS_W-1:0] rdata_reg, rdata_next;
   btd_pkg::btd_ev_t ev;
   logic dbg_taken;
   logic mc_taken;
   logic brk_ev;
   logic xfer;
   logic step_fire;
   logic dbg_entry;

   // ------------------------------------------------------------
   // width check and zero word
   // ------------------------------------------------------------
   localparam logic [OFS_W-1:0] OFS_ZERO = OFS_W'(btd_pkg::OFS_RESET);
   // the status field must fit inside one data word
   if (OFS_W <= btd_pkg::STAT_SINGLE_STEP_BIT) begin : g_width_check
      $error("offset width too narrow for the status word");
   end

   // ------------------------------------------------------------
   // event classification
   // ------------------------------------------------------------
   always_comb begin
      brk_ev = i_retire && dec_break;
      dbg_taken = i_except && i_except_vec == btd_pkg::DEBUG_VECTOR;
      mc_taken = i_except && i_except_vec == btd_pkg::MCHECK_VECTOR;
      if (i_except || brk_ev)
         ev = btd_pkg::BTD_EV_EXCEPT;
      else if (i_retire && i_is_branch)
         ev = btd_pkg::BTD_EV_BRANCH;
      else
         ev = btd_pkg::BTD_EV_NONE;
      xfer = ev != btd_pkg::BTD_EV_NONE && !dbg_taken;
      // coarse or fine stepping
      if (step_en_reg && trap_reg)
         step_fire = xfer;
      else
         step_fire = trap_reg && i_retire && !dbg_taken;
   end

   // ------------------------------------------------------------
   // debug entry
   // ------------------------------------------------------------
   // a debug vector or a step trap both enter the debug handler
   always_comb begin
      dbg_entry = dbg_taken || step_fire;
   end

   // ------------------------------------------------------------
   // control bits: record enable, branch step
   // ------------------------------------------------------------
   // software writes land, debug entry overrides them
   always_comb begin
      rec_en_next = rec_en_reg;
      step_en_next = step_en_reg;
      if (i_wr && i_addr == btd_pkg::ADDR_DEBUG_CTL) begin
         rec_en_next = i_wdata[btd_pkg::CTL_RECORD_BIT];
         step_en_next = i_wdata[btd_pkg::CTL_STEP_BIT];
      end
      if (dbg_entry) begin
         rec_en_next = 1'b0;
         step_en_next = 1'b0;
      end
   end

   // control bit registers
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rec_en_reg <= 1'b0;
         step_en_reg <= 1'b0;
      end else begin
         rec_en_reg <= rec_en_next;
         step_en_reg <= step_en_next;
      end
   end

   // ------------------------------------------------------------
   // trap flag
   // ------------------------------------------------------------
   // the core rewrites it, a debug entry clears it
   always_comb begin
      trap_next = trap_reg;
      if (i_flag_write) begin
         trap_next = i_trap_flag;
      end
      if (dbg_entry) begin
         trap_next = 1'b0;
      end
   end

   // trap flag register
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         trap_reg <= 1'b0;
      end else begin
         trap_reg <= trap_next;
      end
   end

   // ------------------------------------------------------------
   // debug status: single-step bit
   // ------------------------------------------------------------
   // a software write loads the bit, a step trap sets it; the set wins
   always_comb begin
      ss_stat_next = ss_stat_reg;
      if (i_wr && i_addr == btd_pkg::ADDR_DBG_STAT) begin
         ss_stat_next = i_wdata[btd_pkg::STAT_SINGLE_STEP_BIT];
      end
      if (step_fire) begin
         ss_stat_next = 1'b1;
      end
   end

   // status register
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ss_stat_reg <= 1'b0;
      end else begin
         ss_stat_reg <= ss_stat_next;
      end
   end

   // ------------------------------------------------------------
   // branch record pair
   // ------------------------------------------------------------
   // offsets only, the segment base is left to software
   always_comb begin
      br_src_next = br_src_reg;
      br_tgt_next = br_tgt_reg;
      if (rec_en_reg && !dbg_taken) begin
         case (ev)
            btd_pkg::BTD_EV_BRANCH: begin
               br_src_next = i_src_ofs;
               br_tgt_next = i_tgt_ofs;
            end
            btd_pkg::BTD_EV_EXCEPT: begin
               br_src_next = i_src_ofs;
               br_tgt_next = i_handler_ofs;
            end
            default: begin
               br_src_next = br_src_reg;
               br_tgt_next = br_tgt_reg;
            end
         endcase
      end
   end

   // branch record registers
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         br_src_reg <= OFS_ZERO;
         br_tgt_reg <= OFS_ZERO;
      end else begin
         br_src_reg <= br_src_next;
         br_tgt_reg <= br_tgt_next;
      end
   end

   // ------------------------------------------------------------
   // exception record pair
   // ------------------------------------------------------------
   // a copy of the fresh branch pair on taken exceptions;
   // machine check and emulator break leave it alone
   always_comb begin
      ex_src_next = ex_src_reg;
      ex_tgt_next = ex_tgt_reg;
      if (rec_en_reg && !dbg_taken && ev == btd_pkg::BTD_EV_EXCEPT) begin
         if (!mc_taken && !(i_retire && dec_emu)) begin
            ex_src_next = br_src_next;
            ex_tgt_next = br_tgt_next;
         end
      end
   end

   // exception record registers
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ex_src_reg <= OFS_ZERO;
         ex_tgt_reg <= OFS_ZERO;
      end else begin
         ex_src_reg <= ex_src_next;
         ex_tgt_reg <= ex_tgt_next;
      end
   end

   // ------------------------------------------------------------
   // breakpoint request
   // ------------------------------------------------------------
   // one pulse per retired breakpoint opcode, with its length
   always_comb begin
      break_req_next = brk_ev;
      break_len_next = btd_pkg::LEN_ONE;
      if (brk_ev) begin
         break_len_next = dec_len;
      end
   end

   // breakpoint request registers
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         break_req_reg <= 1'b0;
         break_len_reg <= btd_pkg::LEN_ONE;
      end else begin
         break_req_reg <= break_req_next;
         break_len_reg <= break_len_next;
      end
   end

   // ------------------------------------------------------------
   // step trap request
   // ------------------------------------------------------------
   // raised the cycle after the stepped transfer or instruction has retired
   always_comb begin
      dbg_req_next = step_fire;
   end

   // step trap register
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         dbg_req_reg <= 1'b0;
      end else begin
         dbg_req_reg <= dbg_req_next;
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   // only the cycle after a read strobe carries data
   always_comb begin
      rdata_next = OFS_ZERO;
      if (i_rd) begin
         case (i_addr)
            btd_pkg::ADDR_DEBUG_CTL: begin
               rdata_next[btd_pkg::CTL_RECORD_BIT] = rec_en_reg;
               rdata_next[btd_pkg::CTL_STEP_BIT] = step_en_reg;
            end
            btd_pkg::ADDR_BR_SRC: rdata_next = br_src_reg;
            btd_pkg::ADDR_BR_TGT: rdata_next = br_tgt_reg;
            btd_pkg::ADDR_EX_SRC: rdata_next = ex_src_reg;
            btd_pkg::ADDR_EX_TGT: rdata_next = ex_tgt_reg;
            btd_pkg::ADDR_DBG_STAT: begin
               rdata_next[btd_pkg::STAT_SINGLE_STEP_BIT] = ss_stat_reg;
            end
            default: rdata_next = OFS_ZERO;
         endcase
      end
   end

   // read data register
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rdata_reg <= OFS_ZERO;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // read data straight from its register
   assign o_rdata = rdata_reg;
   // requests and the flag seen by the core
   assign o_break_req = break_req_reg;
   assign o_break_len = break_len_reg;
   assign o_debug_req = dbg_req_reg;
   assign o_trap_flag = trap_reg;
endmodule // btd_branch_trace

// [btd_props.sv]
`timescale 1ns/100ps
module btd_props (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_retire,
   input wire logic [7:0] i_op0,
   input wire logic [7:0] i_op1,
   input wire logic i_is_branch,
   input wire logic i_except,
   input wire logic i_trap_flag,
   input wire logic i_flag_write,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic o_break_req,
   input wire logic [1:0] o_break_len,
   input wire logic o_debug_req,
   input wire logic o_trap_flag
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   // breakpoint opcodes seen at retirement
   sequence s_one;
      i_retire && i_op0 == btd_pkg::OP_ONE_BYTE_BREAK;
   endsequence
   sequence s_two;
      i_retire && i_op0 == btd_pkg::OP_SOFT_INT && i_op1 == btd_pkg::BREAK_VECTOR;
   endsequence
   chk_break_one: assert property (s_one |=>
      o_break_req && o_break_len == btd_pkg::LEN_ONE) else $error("one-byte break missed");
   chk_break_two: assert property (s_two |=>
      o_break_req && o_break_len == btd_pkg::LEN_TWO) else $error("two-byte break missed");
   chk_break_cause: assert property (o_break_req |-> $past(i_retire))
      else $error("break request without retirement");
   chk_branch_step: assert property (o_trap_flag && i_retire && i_is_branch |=> o_debug_req)
      else $error("no trap on branch");
   chk_trap_tf: assert property (o_debug_req |-> $past(o_trap_flag))
      else $error("trap without trap flag");
   chk_trap_cause: assert property (o_debug_req |-> $past(i_retire || i_except))
      else $error("trap without event");
   chk_tf_clear: assert property (o_debug_req && !i_flag_write |=> !o_trap_flag)
      else $error("trap flag kept after trap");
   chk_trap_single: assert property (o_debug_req |=> !o_debug_req)
      else $error("trap request repeated");
   chk_tf_write: assert property (i_flag_write && !i_retire && !i_except |=>
      o_trap_flag == $past(i_trap_flag)) else $error("trap flag write lost");
   chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
      else $error("read data outside read slot");
endmodule // btd_props
bind btd_branch_trace btd_props btd_props_i (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_retire(i_retire), .i_op0(i_op0), .i_op1(i_op1), .i_is_branch(i_is_branch),
   .i_except(i_except), .i_trap_flag(i_trap_flag), .i_flag_write(i_flag_write), .i_rd(i_rd),
   .o_rdata(o_rdata), .o_break_req(o_break_req), .o_break_len(o_break_len),
   .o_debug_req(o_debug_req), .o_trap_flag(o_trap_flag));

// [tb.sv]
`timescale 1ns/100ps
module tb;
   logic i_mclk, i_rst = 1'h1, i_retire = 1'h0, i_is_branch = 1'h0, i_except = 1'h0;
   logic i_trap_flag = 1'h0, i_flag_write = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
   logic [7:0] i_op0 = 8'h00, i_op1 = 8'h00, i_except_vec = 8'h00;
   logic [31:0] i_src_ofs = 32'h0, i_tgt_ofs = 32'h0, i_handler_ofs = 32'h0, i_wdata = 32'h0;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] o_rdata;
   logic [1:0] o_break_len;
   logic o_break_req, o_debug_req, o_trap_flag;
   int miscompares = 0, compares = 0, cycles = 0;
   btd_branch_trace btd_branch_trace_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_retire(i_retire),
      .i_op0(i_op0), .i_op1(i_op1), .i_is_branch(i_is_branch), .i_src_ofs(i_src_ofs),
      .i_tgt_ofs(i_tgt_ofs), .i_except(i_except), .i_except_vec(i_except_vec),
      .i_handler_ofs(i_handler_ofs), .i_trap_flag(i_trap_flag), .i_flag_write(i_flag_write),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_break_req(o_break_req), .o_break_len(o_break_len), .o_debug_req(o_debug_req),
      .o_trap_flag(o_trap_flag));
   // clock and hang guard
   initial begin
      i_mclk = 1'h0;
      forever #20 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic conclude;
      if (miscompares == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic ck(string n, logic [31:0] s, logic [31:0] e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // register port cycles
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge i_mclk);
      i_wr <= 1'h1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'h0;
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] e, string n);
      @(posedge i_mclk);
      i_rd <= 1'h1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'h0;
      #1;
      ck(n, o_rdata, e);
   endtask
   // one retirement or exception; second byte doubles as vector
   task automatic ev(logic r, x, b, logic [7:0] o0, o1, logic [31:0] s, t);
      @(posedge i_mclk);
      i_retire <= r;
      i_except <= x;
      i_is_branch <= b;
      i_op0 <= o0;
      i_op1 <= o1;
      i_except_vec <= o1;
      i_src_ofs <= s;
      i_tgt_ofs <= t;
      i_handler_ofs <= t;
      @(posedge i_mclk);
      i_retire <= 1'h0;
      i_except <= 1'h0;
      #1;
   endtask
   task automatic tf(logic v);
      @(posedge i_mclk);
      i_flag_write <= 1'h1;
      i_trap_flag <= v;
      @(posedge i_mclk);
      i_flag_write <= 1'h0;
      repeat (2) @(posedge i_mclk);
   endtask
   task automatic t_break;
      ev(1, 0, 0, btd_pkg::OP_ONE_BYTE_BREAK, 8'h00, 32'h0, 32'h0);
      ck("brk1", 32'({o_break_req, o_break_len}), 32'h5);
      ev(1, 0, 0, btd_pkg::OP_SOFT_INT, btd_pkg::BREAK_VECTOR, 32'h0, 32'h0);
      ck("brk2", 32'({o_break_req, o_break_len}), 32'h6);
      ev(1, 0, 0, btd_pkg::OP_SOFT_INT, 8'h04, 32'h0, 32'h0);
      ck("brk3", 32'(o_break_req), 32'h0);
      ev(1, 0, 0, btd_pkg::OP_ONE_BYTE_BREAK, 8'h00, 32'h0, 32'h0);
      ck("planted", 32'({o_break_req, o_break_len}), 32'h5);
      ev(1, 0, 0, 8'h90, 8'h00, 32'h0, 32'h0);
      ck("restored", 32'(o_break_req), 32'h0);
   endtask
   task automatic t_record;
      ev(1, 0, 1, 8'h90, 8'h00, 32'h1111, 32'h2222);
      rd(btd_pkg::ADDR_BR_SRC, 32'h0, "off");
      wr(btd_pkg::ADDR_DEBUG_CTL, 32'h1);
      ev(1, 0, 1, 8'hEB, 8'h00, 32'h1000, 32'h2000);
      rd(btd_pkg::ADDR_BR_SRC, 32'h1000, "bsrc");
      rd(btd_pkg::ADDR_BR_TGT, 32'h2000, "btgt");
      ev(0, 1, 0, 8'h90, 8'h0E, 32'h3000, 32'h4000);
      rd(btd_pkg::ADDR_BR_TGT, 32'h4000, "xtgt");
      ev(0, 1, 0, 8'h90, btd_pkg::MCHECK_VECTOR, 32'h5000, 32'h6000);
      ev(1, 0, 1, btd_pkg::OP_EMU_BREAK, 8'h00, 32'h7000, 32'h8000);
      wr(btd_pkg::ADDR_DEBUG_CTL, 32'h1);
      ev(0, 1, 0, 8'h90, btd_pkg::DEBUG_VECTOR, 32'h9000, 32'hA000);
      rd(btd_pkg::ADDR_DEBUG_CTL, 32'h0, "ctl");
      rd(btd_pkg::ADDR_BR_SRC, 32'h7000, "ksrc");
      rd(btd_pkg::ADDR_BR_TGT, 32'h8000, "ktgt");
      rd(btd_pkg::ADDR_EX_SRC, 32'h3000, "esrc");
      rd(btd_pkg::ADDR_EX_TGT, 32'h4000, "etgt");
   endtask
   task automatic t_step;
      wr(btd_pkg::ADDR_DEBUG_CTL, 32'h2);
      ev(1, 0, 1, 8'hEB, 8'h00, 32'h0, 32'h0);
      ck("notf", 32'(o_debug_req), 32'h0);
      tf(1'h1);
      ev(1, 0, 0, 8'h90, 8'h00, 32'h0, 32'h0);
      ck("nbr", 32'(o_debug_req), 32'h0);
      ev(1, 0, 1, 8'hEB, 8'h00, 32'h100, 32'h200);
      ck("cstep", 32'(o_debug_req), 32'h1);
      rd(btd_pkg::ADDR_DEBUG_CTL, 32'h0, "sctl");
      ck("tf", 32'(o_trap_flag), 32'h0);
      rd(btd_pkg::ADDR_DBG_STAT, 32'h1 << btd_pkg::STAT_SINGLE_STEP_BIT, "stat");
      wr(btd_pkg::ADDR_DEBUG_CTL, 32'h2);
      tf(1'h1);
      ev(1, 0, 1, 8'hEB, 8'h00, 32'h300, 32'h400);
      ck("rearm", 32'(o_debug_req), 32'h1);
      wr(btd_pkg::ADDR_DBG_STAT, 32'h0);
      tf(1'h1);
      ev(1, 0, 0, 8'h90, 8'h00, 32'h0, 32'h0);
      ck("fstep", 32'(o_debug_req), 32'h1);
   endtask
   // reset, then scenarios
   initial begin
      repeat (16) @(posedge i_mclk);
      i_rst <= 1'h0;
      for (int a = 0; a < 8; a++) begin
         rd(4'(a), 32'h0, "rst");
      end
      ck("len", 32'(o_break_len), 32'h1);
      t_break();
      t_record();
      t_step();
      conclude();
   end
endmodule // tb
